/* File: logic/bridge_irq_and_control_regs.sv */
/*
  Interrupt line byte, interrupt pin code and bridge control register of a
  virtual host-to-link bridge port, with the hot reset request sequencing,
  legacy address forwarding and error reporting gates they steer.
  Assumes single-cycle configuration strobes on CLK, one at a time, and a
  link training machine that reports its L0, L1 and Recovery states.
*/
// What this block does
// (R1) Read-write interrupt routing byte, reset zero, affects nothing inside.
// (R2) Interrupt pin byte is read-only and always returns 01h.
// (R3) Bridge control bits 8 to 11 read zero and ignore writes.
// (R4) Bridge control bits 7 and 5 are hardwired zero.
// (R5) Setting bit 6 requests a hot reset of the link port.
// (R6) Hot reset goes from L0 or L1 through Recovery into Hot Reset.
// (R7) Bit 4 selects 10-bit or 16-bit graphics I/O decode.
// (R8) Bit 4 only matters while graphics enable bit 3 is set.
// (R9) Bit 3 routes legacy graphics I/O and memory cycles to the link.
// (R10) Bit 2 clear: forward every I/O access inside the base-limit window.
// (R11) Bit 2 set: drop last 768 bytes of each 1 KB block.
// (R12) Alias exclusion only trims the window; outside addresses unaffected.
// (R13) Bit 1 gates secondary error messages into system error requests.
// (R14) Bit 0 gates master data parity status on poisoned completions.
// (R15) Reserved bits 12 to 15 read zero, writes discarded.
module bridge_irq_and_control_regs
  import bridge_regs_pkg::*;
(
  input  wire logic        CLK,
  input  wire logic        RST_N,
  input  wire logic        CFG_WR,
  input  wire logic        CFG_RD,
  input  wire logic [7:0]  CFG_ADDR,
  input  wire logic [3:0]  CFG_BE,
  input  wire logic [31:0] CFG_WDATA,
  output logic      [31:0] CFG_RDATA,
  output logic             CFG_RD_VALID,
  output logic             CFG_HIT,
  input  wire logic        LINK_IN_L0,
  input  wire logic        LINK_IN_L1,
  input  wire logic        LINK_IN_RECOVERY,
  output logic             HOT_RESET_REQ,
  output logic             LINK_DIRECT_RECOVERY,
  output logic             LINK_DIRECT_HOT_RESET,
  input  wire logic [15:0] IO_ADDR,
  input  wire logic [31:0] MEM_ADDR,
  input  wire logic [15:0] IO_WINDOW_BASE,
  input  wire logic [15:0] IO_WINDOW_LIMIT,
  output logic             IO_FORWARD,
  output logic             MEM_GRAPHICS_FORWARD,
  input  wire logic        ERR_MSG_COR,
  input  wire logic        ERR_MSG_NONFATAL,
  input  wire logic        ERR_MSG_FATAL,
  input  wire logic        ROOT_EN_COR,
  input  wire logic        ROOT_EN_NONFATAL,
  input  wire logic        ROOT_EN_FATAL,
  output logic             SYSTEM_ERROR_REQ,
  input  wire logic        POISONED_READ_CPL,
  output logic             PARITY_ERROR_SET
);

  typedef enum logic [1:0] {
    LINK_IDLE,
    LINK_TO_RECOVERY,
    LINK_HOT_RESET
  } hot_reset_state_e;

  hot_reset_state_e  hot_reset_state;
  hot_reset_state_e  next_hot_reset_state;

  logic [7:0]  irq_routing_value;
  logic [15:0] bridge_control;
  logic [15:0] control_view;
  logic        dword_hit;
  logic        io_forward_raw;
  logic        mem_forward_raw;
  logic        secondary_hot_reset;
  logic        graphics_wide_decode;
  logic        graphics_route_enable;
  logic        legacy_alias_exclude;
  logic        error_forward_enable;
  logic        parity_response_enable;

  // merge write data into a byte under its enable
  function automatic logic [7:0] merge_byte(input logic [7:0] old_value,
                                            input logic [7:0] new_value,
                                            input logic       enable);
    merge_byte = enable ? new_value : old_value;
  endfunction

  // one dword at 3Ch holds all three registers
  always_comb begin
    if ((CFG_ADDR & DWORD_MASK) == IRQ_ROUTING_BYTE_OFS) begin
      dword_hit = 1'b1;
    end else begin
      dword_hit = 1'b0;
    end
  end

  assign CFG_HIT = dword_hit;

  // field views of the stored control bits
  assign secondary_hot_reset    = bridge_control[SECONDARY_RESET_BIT];
  assign graphics_wide_decode   = bridge_control[GRAPHICS_WIDE_BIT];
  assign graphics_route_enable  = bridge_control[GRAPHICS_ROUTE_BIT];
  assign legacy_alias_exclude   = bridge_control[LEGACY_ALIAS_BIT];
  assign error_forward_enable   = bridge_control[ERROR_FORWARD_BIT];
  assign parity_response_enable = bridge_control[PARITY_RESPONSE_BIT];

  // routing byte: stored for software only
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      irq_routing_value <= IRQ_ROUTING_RESET; // (R1)
    end else if (CFG_WR && dword_hit) begin
      irq_routing_value <= merge_byte(irq_routing_value, // (R1)
                                      CFG_WDATA[7:0], CFG_BE[0]);
    end
  end

  // bridge control: only writable bits are kept
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      bridge_control <= BRIDGE_CONTROL_RESET;
    end else if (CFG_WR && dword_hit) begin
      bridge_control <= {merge_byte(bridge_control[15:8],
                                    CFG_WDATA[31:24], CFG_BE[3]),
                         merge_byte(bridge_control[7:0],
                                    CFG_WDATA[23:16], CFG_BE[2])}
                        & BRIDGE_CONTROL_WMASK; // (R3) (R4) (R15)
    end
  end

  // readback: hardwired and reserved bits forced to zero
  always_comb begin
    control_view = bridge_control & BRIDGE_CONTROL_WMASK;
    control_view[DISCARD_HI_BIT:DISCARD_LO_BIT]   = 4'h0; // (R3)
    control_view[BACK_TO_BACK_BIT]                = 1'b0; // (R4)
    control_view[ABORT_MODE_BIT]                  = 1'b0; // (R4)
    control_view[RESERVED_HI_BIT:RESERVED_LO_BIT] = 4'h0; // (R15)
  end

  // read data registered, one cycle after the strobe
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      CFG_RDATA <= 32'h00000000;
    end else if (CFG_RD) begin
      if (dword_hit) begin
        CFG_RDATA <= {control_view, IRQ_PIN_CODE_VALUE, // (R2)
                      irq_routing_value};
      end else begin
        CFG_RDATA <= 32'h00000000;
      end
    end
  end

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      CFG_RD_VALID <= 1'b0;
    end else begin
      CFG_RD_VALID <= CFG_RD;
    end
  end

  // hot reset request follows the stored bit
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      HOT_RESET_REQ <= 1'b0;
    end else begin
      HOT_RESET_REQ <= secondary_hot_reset; // (R5)
    end
  end

  // hot reset sequencing towards the training machine
  always_comb begin
    next_hot_reset_state = hot_reset_state;
    case (hot_reset_state)
      LINK_IDLE: begin
        if (secondary_hot_reset && (LINK_IN_L0 || LINK_IN_L1)) begin
          next_hot_reset_state = LINK_TO_RECOVERY; // (R6)
        end
      end
      LINK_TO_RECOVERY: begin
        if (!secondary_hot_reset) begin
          next_hot_reset_state = LINK_IDLE;
        end else if (LINK_IN_RECOVERY) begin
          next_hot_reset_state = LINK_HOT_RESET; // (R6)
        end
      end
      LINK_HOT_RESET: begin
        if (!secondary_hot_reset) begin
          next_hot_reset_state = LINK_IDLE;
        end
      end
      default: begin
        next_hot_reset_state = LINK_IDLE;
      end
    endcase
  end

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      hot_reset_state <= LINK_IDLE;
    end else begin
      hot_reset_state <= next_hot_reset_state; // (R6)
    end
  end

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      LINK_DIRECT_RECOVERY  <= 1'b0;
      LINK_DIRECT_HOT_RESET <= 1'b0;
    end else begin
      LINK_DIRECT_RECOVERY  <= (next_hot_reset_state == LINK_TO_RECOVERY);
      LINK_DIRECT_HOT_RESET <= (next_hot_reset_state == LINK_HOT_RESET);
    end
  end

  // address forwarding decode
  legacy_io_decode u_decode (
    .io_addr               (IO_ADDR),
    .mem_addr              (MEM_ADDR),
    .io_window_base        (IO_WINDOW_BASE),
    .io_window_limit       (IO_WINDOW_LIMIT),
    .graphics_route_enable (graphics_route_enable),
    .graphics_wide_decode  (graphics_wide_decode),
    .legacy_alias_exclude  (legacy_alias_exclude),
    .io_forward            (io_forward_raw),
    .mem_graphics_forward  (mem_forward_raw)
  );

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      IO_FORWARD           <= 1'b0;
      MEM_GRAPHICS_FORWARD <= 1'b0;
    end else begin
      IO_FORWARD           <= io_forward_raw; // (R10) (R11) (R12)
      MEM_GRAPHICS_FORWARD <= mem_forward_raw; // (R9)
    end
  end

  // secondary error messages gated into a system error pulse
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      SYSTEM_ERROR_REQ <= 1'b0;
    end else begin
      SYSTEM_ERROR_REQ <= error_forward_enable && // (R13)
                          ((ERR_MSG_COR && ROOT_EN_COR) ||
                           (ERR_MSG_NONFATAL && ROOT_EN_NONFATAL) ||
                           (ERR_MSG_FATAL && ROOT_EN_FATAL));
    end
  end

  // poisoned completion may set parity status only when enabled
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      PARITY_ERROR_SET <= 1'b0;
    end else begin
      PARITY_ERROR_SET <= parity_response_enable && POISONED_READ_CPL; // (R14)
    end
  end

endmodule // bridge_irq_and_control_regs

/* File: logic/bridge_regs_pkg.sv */
/*
  Constants for the bridge interrupt and control register bank:
  configuration offsets, bridge control field positions, reset values
  and legacy graphics address ranges.
  Assumes configuration accesses address aligned 32-bit dwords by byte offset.
*/
package bridge_regs_pkg;

  // configuration byte offsets
  localparam logic [7:0]  IRQ_ROUTING_BYTE_OFS = 8'h3C;
  localparam logic [7:0]  IRQ_PIN_CODE_OFS     = 8'h3D;
  localparam logic [7:0]  BRIDGE_CONTROL_OFS   = 8'h3E;
  localparam logic [7:0]  DWORD_MASK           = 8'hFC;

  // reset values
  localparam logic [7:0]  IRQ_ROUTING_RESET    = 8'h00;
  localparam logic [7:0]  IRQ_PIN_CODE_VALUE   = 8'h01;
  localparam logic [15:0] BRIDGE_CONTROL_RESET = 16'h0000;

  // bridge control bit positions
  localparam int PARITY_RESPONSE_BIT   = 0;
  localparam int ERROR_FORWARD_BIT     = 1;
  localparam int LEGACY_ALIAS_BIT      = 2;
  localparam int GRAPHICS_ROUTE_BIT    = 3;
  localparam int GRAPHICS_WIDE_BIT     = 4;
  localparam int ABORT_MODE_BIT        = 5;
  localparam int SECONDARY_RESET_BIT   = 6;
  localparam int BACK_TO_BACK_BIT      = 7;
  localparam int DISCARD_LO_BIT        = 8;
  localparam int DISCARD_HI_BIT        = 11;
  localparam int RESERVED_LO_BIT       = 12;
  localparam int RESERVED_HI_BIT       = 15;

  // writable bits of bridge control: 6, 4, 3, 2, 1, 0
  localparam logic [15:0] BRIDGE_CONTROL_WMASK = 16'h005F;

  // legacy graphics ranges
  localparam logic [9:0]  GFX_IO_MONO_LO   = 10'h3B0;
  localparam logic [9:0]  GFX_IO_MONO_HI   = 10'h3BB;
  localparam logic [9:0]  GFX_IO_COLOR_LO  = 10'h3C0;
  localparam logic [9:0]  GFX_IO_COLOR_HI  = 10'h3DF;
  localparam logic [31:0] GFX_MEM_LO       = 32'h000A0000;
  localparam logic [31:0] GFX_MEM_HI       = 32'h000BFFFF;

  // alias exclusion: offsets 100h..3FFh of each 1 KB block
  localparam int ALIAS_SEL_LO = 8;
  localparam int ALIAS_SEL_HI = 9;
  localparam int WIDE_LO      = 10;

endpackage

/* File: logic/legacy_io_decode.sv */
/*
  Combinational decode of processor I/O and memory addresses against the
  I/O window, the legacy graphics ranges and the alias exclusion.
  Assumes the window base and limit come from the bridge window registers.
*/
module legacy_io_decode
  import bridge_regs_pkg::*;
(
  input  wire logic [15:0] io_addr,
  input  wire logic [31:0] mem_addr,
  input  wire logic [15:0] io_window_base,
  input  wire logic [15:0] io_window_limit,
  input  wire logic        graphics_route_enable,
  input  wire logic        graphics_wide_decode,
  input  wire logic        legacy_alias_exclude,
  output logic             io_forward,
  output logic             mem_graphics_forward
);

  logic in_window;
  logic alias_hit;
  logic gfx_low_hit;
  logic gfx_io_hit;

  function automatic logic in_range(input logic [9:0] a,
                                    input logic [9:0] lo,
                                    input logic [9:0] hi);
    in_range = (a >= lo) && (a <= hi);
  endfunction

  always_comb begin
    in_window   = (io_addr >= io_window_base) && (io_addr <= io_window_limit);
    alias_hit   = |io_addr[ALIAS_SEL_HI:ALIAS_SEL_LO];
    gfx_low_hit = in_range(io_addr[9:0], GFX_IO_MONO_LO, GFX_IO_MONO_HI) ||
                  in_range(io_addr[9:0], GFX_IO_COLOR_LO, GFX_IO_COLOR_HI);
    // wide decode only counts while graphics routing is on
    if (graphics_wide_decode) begin // (R7)
      gfx_io_hit = gfx_low_hit && (io_addr[15:WIDE_LO] == 6'h00); // (R7)
    end else begin
      gfx_io_hit = gfx_low_hit; // (R7)
    end
    io_forward = (in_window && !(legacy_alias_exclude && alias_hit)) || // (R10)
                 (graphics_route_enable && gfx_io_hit); // (R8)
    mem_graphics_forward = graphics_route_enable && // (R9)
                           (mem_addr >= GFX_MEM_LO) && (mem_addr <= GFX_MEM_HI);
  end

endmodule // legacy_io_decode

/* File: test/bridge_irq_and_control_regs_test.sv */
/* bench for the bridge interrupt and control register bank
   assumes the bench drives every input; no far-side model */
module bridge_irq_and_control_regs_test
  import bridge_regs_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic        CLK, RST_N, CFG_WR, CFG_RD, CFG_RD_VALID, CFG_HIT;
  logic [7:0]  CFG_ADDR, rb, ctl;
  logic [3:0]  CFG_BE;
  logic [31:0] CFG_WDATA, CFG_RDATA, MEM_ADDR;
  logic [15:0] IO_ADDR, IO_WINDOW_BASE, IO_WINDOW_LIMIT;
  logic        LINK_IN_L0, LINK_IN_L1, LINK_IN_RECOVERY, HOT_RESET_REQ;
  logic        LINK_DIRECT_RECOVERY, LINK_DIRECT_HOT_RESET, IO_FORWARD;
  logic        MEM_GRAPHICS_FORWARD, ERR_MSG_COR, ERR_MSG_NONFATAL;
  logic        ERR_MSG_FATAL, ROOT_EN_COR, ROOT_EN_NONFATAL, ROOT_EN_FATAL;
  logic        SYSTEM_ERROR_REQ, POISONED_READ_CPL, PARITY_ERROR_SET;
  logic        probe, probe_d;
  logic [31:0] exp_rd[$];
  logic [6:0]  exp_out[$];
  int          num_errors, comparisons, m, i;

  bridge_irq_and_control_regs dut (.*);

  initial begin
    CLK = 1'b0;
    forever #25 CLK = ~CLK;
  end

  task automatic check(string what, logic [31:0] exp, logic [31:0] got);
    comparisons++;
    if (exp !== got) begin
      num_errors++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic test_done;
    if (exp_rd.size() != 0 || exp_out.size() != 0) begin
      num_errors++;
      $display("BAD queue expected %0d seen %0d", 0,
               exp_rd.size() + exp_out.size());
    end
    $display("comparisons %0d errors %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // watcher: oldest note against each result
  always @(posedge CLK) begin
    if (CFG_RD_VALID === 1'b1)
      check("read data", exp_rd.pop_front(), CFG_RDATA);
    if (probe_d === 1'b1)
      check("outputs", 32'(exp_out.pop_front()),
        32'({HOT_RESET_REQ, LINK_DIRECT_RECOVERY, LINK_DIRECT_HOT_RESET,
        IO_FORWARD, MEM_GRAPHICS_FORWARD, SYSTEM_ERROR_REQ,
        PARITY_ERROR_SET}));
    probe_d <= probe;
  end

  task automatic cfg_wr(logic [7:0] a, logic [3:0] be, logic [31:0] d);
    @(posedge CLK);
    probe <= 1'b0;
    CFG_WR <= 1'b1;
    CFG_ADDR <= a;
    CFG_BE <= be;
    CFG_WDATA <= d;
    @(posedge CLK);
    CFG_WR <= 1'b0;
    if ((a & DWORD_MASK) == 8'h3C) begin
      if (be[0]) rb = d[7:0];
      if (be[2]) ctl = d[23:16] & 8'h5F;
    end
  endtask

  task automatic cfg_rd(logic [7:0] a);
    @(posedge CLK);
    probe <= 1'b0;
    CFG_RD <= 1'b1;
    CFG_ADDR <= a;
    exp_rd.push_back((a & DWORD_MASK) == 8'h3C ? {8'h00, ctl, 8'h01, rb} : 0);
    @(posedge CLK);
    CFG_RD <= 1'b0;
  endtask

  // one cycle of random traffic, expected outputs one edge later
  task automatic step(logic [2:0] link, logic [2:0] hr);
    logic [15:0] a, b, l;
    logic [31:0] mem;
    logic [2:0]  err, en;
    logic        pois, gfx;
    @(posedge CLK);
    b = 16'($urandom_range(0, 32'h8000));
    l = b + 16'($urandom_range(0, 32'h1000));
    case ($urandom_range(0, 2))
      0: a = 16'($urandom);
      1: a = b - 16'h4 + 16'($urandom_range(0, 32'(l - b) + 8));
      default: a = {5'h0, 1'($urandom), 10'h3A0 + 10'($urandom_range(0, 72))};
    endcase
    mem = 32'h0009FFF0 + $urandom_range(0, 32'h20020);
    {err, en, pois} = 7'($urandom);
    gfx = (a[9:0] >= GFX_IO_MONO_LO && a[9:0] <= GFX_IO_MONO_HI) ||
          (a[9:0] >= GFX_IO_COLOR_LO && a[9:0] <= GFX_IO_COLOR_HI);
    {LINK_IN_L0, LINK_IN_L1, LINK_IN_RECOVERY} <= link;
    {IO_ADDR, IO_WINDOW_BASE, IO_WINDOW_LIMIT, MEM_ADDR} <= {a, b, l, mem};
    {ERR_MSG_COR, ERR_MSG_NONFATAL, ERR_MSG_FATAL} <= err;
    {ROOT_EN_COR, ROOT_EN_NONFATAL, ROOT_EN_FATAL} <= en;
    POISONED_READ_CPL <= pois;
    probe <= 1'b1;
    exp_out.push_back({hr,
      (a >= b && a <= l && !(ctl[2] && a[9:8] != 2'b00)) ||
      (ctl[3] && gfx && (!ctl[4] || a[15:10] == 6'h00)),
      ctl[3] && mem >= GFX_MEM_LO && mem <= GFX_MEM_HI,
      ctl[1] && |(err & en), ctl[0] && pois});
  endtask

  initial begin
    {CFG_WR, CFG_RD, CFG_ADDR, CFG_BE, CFG_WDATA, MEM_ADDR} = '0;
    {IO_ADDR, IO_WINDOW_BASE, IO_WINDOW_LIMIT, POISONED_READ_CPL} = '0;
    {LINK_IN_L0, LINK_IN_L1, LINK_IN_RECOVERY, ERR_MSG_COR} = '0;
    {ERR_MSG_NONFATAL, ERR_MSG_FATAL, ROOT_EN_COR} = '0;
    {ROOT_EN_NONFATAL, ROOT_EN_FATAL, probe, probe_d, rb, ctl, RST_N} = '0;
    num_errors = 0;
    comparisons = 0;
    void'($urandom(32'h5B8087DD));
    repeat (20) @(posedge CLK);
    RST_N <= 1'b1;
    cfg_rd(8'h3C);
    cfg_wr(8'h3C, 4'hF, 32'hFFFF_FFFF);
    cfg_rd(8'h3F);
    cfg_wr(8'h40, 4'hF, 32'h0);
    cfg_rd(8'h40);
    cfg_rd(8'h3D);
    for (i = 0; i < 12; i++) begin
      cfg_wr(8'h3C + 8'($urandom_range(0, 3)), 4'($urandom), $urandom);
      cfg_rd(8'h3C);
    end
    for (m = 0; m < 32; m++) begin
      cfg_wr(8'h3E, 4'h4, {11'h0, 5'(m), 16'h0});
      repeat (24) step(3'($urandom), 3'b000);
    end
    step(3'b100, 3'b000);
    cfg_wr(8'h3E, 4'h4, 32'h0040_0000);
    repeat (2) step(3'b100, 3'b110);
    repeat (2) step(3'b101, 3'b101);
    cfg_wr(8'h3E, 4'h4, 32'h0);
    step(3'b000, 3'b000);
    cfg_wr(8'h3E, 4'h4, 32'h0040_0000);
    step(3'b000, 3'b100);
    repeat (2) step(3'b010, 3'b110);
    cfg_wr(8'h3E, 4'h4, 32'h0);
    step(3'b000, 3'b000);
    @(posedge CLK);
    probe <= 1'b0;
    repeat (3) @(posedge CLK);
    test_done();
  end

  initial begin
    repeat (5000) @(posedge CLK);
    num_errors++;
    test_done();
  end
endmodule // bridge_irq_and_control_regs_test

/* File: test/bridge_regs_properties.sv */
/* checker: config access and hot reset properties of the register bank
   assumes binding to the bank top, seeing its ports by name */
module bridge_regs_properties (
  input wire logic        CLK,
  input wire logic        RST_N,
  input wire logic        CFG_WR,
  input wire logic        CFG_RD,
  input wire logic [7:0]  CFG_ADDR,
  input wire logic [3:0]  CFG_BE,
  input wire logic [31:0] CFG_WDATA,
  input wire logic [31:0] CFG_RDATA,
  input wire logic        CFG_RD_VALID,
  input wire logic        CFG_HIT,
  input wire logic        LINK_IN_L0,
  input wire logic        LINK_IN_L1,
  input wire logic        LINK_IN_RECOVERY,
  input wire logic        HOT_RESET_REQ,
  input wire logic        LINK_DIRECT_RECOVERY,
  input wire logic        LINK_DIRECT_HOT_RESET
);
  default clocking @(posedge CLK); endclocking
  default disable iff (!RST_N);

  a_hit_decode: assert property (
    CFG_HIT == ((CFG_ADDR & 8'hFC) == 8'h3C))
    else $error("dword hit decode wrong");
  a_routing_readback: assert property (
    CFG_WR && CFG_HIT && CFG_BE[0] ##1 !CFG_WR ##1 CFG_RD && CFG_HIT
    |=> CFG_RDATA[7:0] == $past(CFG_WDATA[7:0], 3))
    else $error("routing byte readback wrong");
  a_pin_code_fixed: assert property (
    CFG_RD && CFG_HIT |=> CFG_RDATA[15:8] == 8'h01)
    else $error("pin code not 01");
  a_discard_bits_zero: assert property (
    CFG_RD && CFG_HIT |=> CFG_RD_VALID && CFG_RDATA[27:24] == 4'h0)
    else $error("discard timer bits not zero");
  a_fixed_bits_zero: assert property (
    CFG_RD && CFG_HIT |=> !CFG_RDATA[23] && !CFG_RDATA[21])
    else $error("bits 7 or 5 not zero");
  a_reserved_zero: assert property (
    CFG_RD |=> CFG_RD_VALID && CFG_RDATA[31:28] == 4'h0)
    else $error("reserved bits not zero");
  a_reset_request: assert property (
    CFG_WR && CFG_HIT && CFG_BE[2]
    |=> ##1 HOT_RESET_REQ == $past(CFG_WDATA[22], 2))
    else $error("hot reset request does not follow bit 6");
  a_recovery_from_active: assert property (
    $rose(LINK_DIRECT_RECOVERY)
    |-> HOT_RESET_REQ && ($past(LINK_IN_L0) || $past(LINK_IN_L1)))
    else $error("recovery directive without L0 or L1");
  a_hot_reset_entry: assert property (
    LINK_DIRECT_RECOVERY && LINK_IN_RECOVERY && !$past(CFG_WR)
    |=> LINK_DIRECT_HOT_RESET && !LINK_DIRECT_RECOVERY)
    else $error("no hot reset after recovery");
  a_hot_reset_kept: assert property (
    LINK_DIRECT_HOT_RESET && !CFG_WR && !$past(CFG_WR)
    |=> LINK_DIRECT_HOT_RESET [*2])
    else $error("hot reset directive dropped");
endmodule // bridge_regs_properties

bind bridge_irq_and_control_regs bridge_regs_properties chk (.*);
